// ### pkg/sps_pkg.sv
// Summary of operation
// - three-bit mode picks off, clocked sync, or async with 7/8/9 data bits
// - clock source bit: 0 internal divided clock, 1 external clock pin
// - stop length bit: 0 one stop bit, 1 two stop bits on transmit
// - parity on adds/checks parity; sense 0 odd, 1 even; sense unused otherwise
// - sync mode leaves framing, parity and summary error flags meaningless
// - sync mode transfers exactly eight data bits
// - internal clock is prescaled source over twice the sum of divisor and one
// - external sync transfer clock comes straight from the clock pin
// - transmit starts only with transmit enabled and buffer holding data, or in sync continuous receive after a buffer read
// - sync receive needs both enables and transmit data (or a continuous-mode buffer read), transmit makes clock
// - transmit flag on buffer move (select 0) or on shift complete (select 1)
// - receive flag rises when a finished character enters the receive buffer while no overrun is flagged
// - seventh bit of new character with buffer unread flags overrun, done flag kept
// - polarity 0 drives on falling, samples on rising; 1 the reverse
// - bit order selects LSB first or MSB first for sync transmit and receive; async is always LSB first
// - continuous receive: reading receive buffer starts the next reception
// - noise filter: three samples at 16x rate must agree, else hold level
package sps_pkg;
  localparam int          ADDR_W     = 12;
  localparam logic [9:0]  IDX_MODE   = 10'h080;
  localparam logic [9:0]  IDX_DIV    = 10'h081;
  localparam logic [9:0]  IDX_TXL    = 10'h082;
  localparam logic [9:0]  IDX_TXH    = 10'h083;
  localparam logic [9:0]  IDX_C0     = 10'h084;
  localparam logic [9:0]  IDX_C1     = 10'h085;
  localparam logic [9:0]  IDX_RXL    = 10'h086;
  localparam logic [9:0]  IDX_RXH    = 10'h087;
  localparam logic [9:0]  IDX_IRQ    = 10'h088;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  C0_RST     = 8'h08;
  localparam logic [7:0]  C1_RST     = 8'h02;
  localparam logic [7:0]  IRQ_RST    = 8'h00;
  localparam logic [7:0]  C0_WMASK   = 8'hD3;
  localparam logic [2:0]  MODE_OFF   = 3'h0;
  localparam logic [2:0]  MODE_SYNC  = 3'h1;
  localparam int          MR_CKSRC   = 3;
  localparam int          MR_STOP    = 4;
  localparam int          MR_PSENSE  = 5;
  localparam int          MR_PON     = 6;
  localparam int          C0_TXEPT   = 3;
  localparam int          C0_DFE     = 4;
  localparam int          C0_POL     = 6;
  localparam int          C0_MSB     = 7;
  localparam int          C1_TE      = 0;
  localparam int          C1_TI      = 1;
  localparam int          C1_RE      = 2;
  localparam int          C1_RI      = 3;
  localparam int          C1_IRS     = 4;
  localparam int          C1_CONT    = 5;
  localparam int          IRQ_TXF    = 2;
  localparam int          IRQ_RXF    = 3;
  localparam logic [1:0]  PRE_F8     = 2'h1;
  localparam logic [1:0]  PRE_F32    = 2'h2;
  localparam logic [3:0]  NBITS_BASE = 4'h7;
  localparam logic [3:0]  SYNC_LAST  = 4'h7;
  localparam logic [3:0]  OVR_IDX    = 4'h6;
  localparam logic [3:0]  OVS_MID    = 4'h7;
  localparam logic [3:0]  OVS_LAST   = 4'hF;
  typedef enum logic [1:0] {
    SPS_TX_IDLE = 2'b00,
    SPS_TX_SYNC = 2'b01,
    SPS_TX_UART = 2'b10
  } sps_tx_st_t;
  typedef enum logic [1:0] {
    SPS_RX_IDLE = 2'b00,
    SPS_RX_SYNC = 2'b01,
    SPS_RX_HUNT = 2'b10,
    SPS_RX_UART = 2'b11
  } sps_rx_st_t;
endpackage

// ### hw/sps_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module sps_clk_div #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // rate setting
  input  wire logic [1:0]       pre_sel,
  input  wire logic [DIV_W-1:0] divisor,
  // one-cycle enable at fi/(n+1)
  output logic                  tick
);
  logic [4:0]       pre_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic             pre_en;

  always_comb begin
    if (pre_sel == sps_pkg::PRE_F8) begin
      pre_en = (pre_ff[2:0] == 3'h7);
    end else if (pre_sel == sps_pkg::PRE_F32) begin
      pre_en = (pre_ff == 5'h1F);
    end else begin
      pre_en = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 5'h00;
    end else begin
      pre_ff <= pre_ff + 5'h01;
    end
  end

  // half period of the transfer clock is n+1 source cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (pre_en) begin
      cnt_ff <= (cnt_ff >= divisor) ? '0 : cnt_ff + 1'b1;
    end
  end

  assign tick = pre_en && (cnt_ff >= divisor);
endmodule
`default_nettype wire

// ### hw/sps_rx_filter.sv
`timescale 1ns/10ps
`default_nettype none
module sps_rx_filter (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic sample_en,
  input  wire logic filt_on,
  // line
  input  wire logic rx_in,
  output logic      rx_out
);
  logic [2:0] lat_ff;
  logic       out_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_ff <= 3'h7;
    end else if (sample_en) begin
      lat_ff <= {lat_ff[1:0], rx_in};
    end
  end

  // disagreement is noise: keep the last agreed level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= 1'b1;
    end else if ((&lat_ff) || !(|lat_ff)) begin
      out_ff <= lat_ff[0];
    end
  end

  assign rx_out = filt_on ? out_ff : rx_in;

  filter_agree_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(out_ff) |-> $past(lat_ff) == {3{out_ff}})
    else $error("filter passed a level without three agreeing samples");
endmodule
`default_nettype wire

// ### hw/sps_top.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sps_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  output logic             serial_tx_pin,
  input  wire logic        serial_rx_pin,
  input  wire logic        serial_clock_pin,
  output logic             serial_clock_out,
  output logic             serial_clock_oe,
  // event flags
  output logic             tx_irq_flag,
  output logic             rx_done_flag
);
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [7:0]  mode_ff, div_ff, c0_ff;
  logic [8:0]  txb_ff, rxb_ff;
  logic        te_ff, re_ff, irs_ff, cont_ff, ti_ff, ri_ff, arm_ff;
  logic        ovr_ff, fer_ff, per_ff, txf_ff, rxf_ff;
  logic        acc, wr, rd, hit;
  logic [9:0]  idx;
  logic [7:0]  rd_mux;
  logic [2:0]  mode;
  logic        is_sync, is_uart, ext, pol, msb, pon, psense;
  logic [3:0]  nbits;
  logic        tick, pin_prev_ff, pin_rise, pin_fall, ub;
  logic        clk_lvl_ff, drive_ev, sample_ev;
  sps_pkg::sps_tx_st_t tx_st_ff;
  sps_pkg::sps_rx_st_t rx_st_ff;
  logic [12:0] frame, tx_frame_ff;
  logic [3:0]  frame_len, tx_len_ff, tx_idx_ff, tx_ovs_ff;
  logic        tx_pin_ff, sync_start, uart_start, tx_load, tx_end, tx_idle;
  logic [10:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0]  rx_idx_ff, rx_ovs_ff, rx_total;
  logic        rx_filt, rx_bit, rx_take, rx_last, rx_store, ovr_hit;
  logic [8:0]  rx_data;
  logic        rx_fer, rx_per, p_calc;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // apb decode, zero wait states
  assign idx     = paddr[11:2];
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && hit;
  assign rd      = acc && !pwrite && hit;
  assign hit     = (idx >= sps_pkg::IDX_MODE) && (idx <= sps_pkg::IDX_IRQ);
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = rd ? {24'h000000, rd_mux} : 32'h00000000;

  // mode decode
  assign mode    = mode_ff[2:0];
  assign is_sync = (mode == sps_pkg::MODE_SYNC);
  assign is_uart = mode[2] && !(mode[1] && mode[0]);
  assign nbits   = sps_pkg::NBITS_BASE + {2'h0, mode[1:0]};
  assign ext     = mode_ff[sps_pkg::MR_CKSRC];
  assign pon     = mode_ff[sps_pkg::MR_PON];
  assign psense  = mode_ff[sps_pkg::MR_PSENSE];
  assign pol     = c0_ff[sps_pkg::C0_POL];
  assign msb     = c0_ff[sps_pkg::C0_MSB];
  assign tx_idle = (tx_st_ff == sps_pkg::SPS_TX_IDLE);

  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      sps_pkg::IDX_MODE: rd_mux = mode_ff;
      sps_pkg::IDX_DIV:  rd_mux = div_ff;
      sps_pkg::IDX_C0:   rd_mux = c0_ff | {4'h0, tx_idle, 3'h0};
      sps_pkg::IDX_C1:   rd_mux = {2'h0, cont_ff, irs_ff, ri_ff, re_ff, ti_ff, te_ff};
      sps_pkg::IDX_RXL:  rd_mux = rxb_ff[7:0];
      sps_pkg::IDX_RXH:  rd_mux = {ovr_ff | fer_ff | per_ff, per_ff, fer_ff, ovr_ff,
                                   3'h0, rxb_ff[8]};
      sps_pkg::IDX_IRQ:  rd_mux = {4'h0, rxf_ff, txf_ff, 2'h0};
      default:           rd_mux = 8'h00;
    endcase
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= sps_pkg::MODE_RST;
      div_ff  <= 8'h00;
      c0_ff   <= sps_pkg::C0_RST & sps_pkg::C0_WMASK;
      te_ff   <= sps_pkg::C1_RST[sps_pkg::C1_TE];
      re_ff   <= sps_pkg::C1_RST[sps_pkg::C1_RE];
      irs_ff  <= sps_pkg::C1_RST[sps_pkg::C1_IRS];
      cont_ff <= sps_pkg::C1_RST[sps_pkg::C1_CONT];
      txb_ff  <= 9'h000;
    end else if (wr) begin
      case (idx)
        sps_pkg::IDX_MODE: mode_ff <= {1'b0, pwdata[6:0]};
        sps_pkg::IDX_DIV:  div_ff <= pwdata[7:0];
        sps_pkg::IDX_TXL:  txb_ff[7:0] <= pwdata[7:0];
        sps_pkg::IDX_TXH:  txb_ff[8] <= pwdata[0];
        sps_pkg::IDX_C0:   c0_ff <= pwdata[7:0] & sps_pkg::C0_WMASK;
        sps_pkg::IDX_C1: begin
          te_ff   <= pwdata[sps_pkg::C1_TE];
          re_ff   <= pwdata[sps_pkg::C1_RE];
          irs_ff  <= pwdata[sps_pkg::C1_IRS];
          cont_ff <= pwdata[sps_pkg::C1_CONT];
        end
        default: ;
      endcase
    end
  end

  // buffer-empty flag: a new write beats the move so fresh data is never dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ti_ff <= sps_pkg::C1_RST[sps_pkg::C1_TI];
    end else if (wr && idx == sps_pkg::IDX_TXL) begin
      ti_ff <= 1'b0;
    end else if (tx_load) begin
      ti_ff <= 1'b1;
    end
  end

  // event flags: hardware set wins over a software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txf_ff <= sps_pkg::IRQ_RST[sps_pkg::IRQ_TXF];
      rxf_ff <= sps_pkg::IRQ_RST[sps_pkg::IRQ_RXF];
    end else begin
      if ((irs_ff ? tx_end : tx_load)) begin
        txf_ff <= 1'b1;
      end else if (wr && idx == sps_pkg::IDX_IRQ && !pwdata[sps_pkg::IRQ_TXF]) begin
        txf_ff <= 1'b0;
      end
      if (rx_store && !ovr_ff && !ovr_hit) begin
        rxf_ff <= 1'b1;
      end else if (wr && idx == sps_pkg::IDX_IRQ && !pwdata[sps_pkg::IRQ_RXF]) begin
        rxf_ff <= 1'b0;
      end
    end
  end
  assign tx_irq_flag  = txf_ff;
  assign rx_done_flag = rxf_ff;

  // clock generation and edge events
  sps_clk_div #(
    .DIV_W(8)
  ) u_div (
    .sys_clk(sys_clk),
    .rst_n  (rst_n),
    .pre_sel(c0_ff[1:0]),
    .divisor(div_ff),
    .tick   (tick)
  );

  // pin is taken as synchronous, so one flop suffices for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_ff <= 1'b1;
    end else begin
      pin_prev_ff <= serial_clock_pin;
    end
  end
  assign pin_rise = serial_clock_pin && !pin_prev_ff;
  assign pin_fall = !serial_clock_pin && pin_prev_ff;
  assign ub       = ext ? pin_rise : tick;

  always_comb begin
    if (ext) begin
      drive_ev  = pol ? pin_rise : pin_fall;
      sample_ev = pol ? pin_fall : pin_rise;
    end else begin
      drive_ev  = tick && (clk_lvl_ff == !pol);
      sample_ev = tick && (clk_lvl_ff == pol);
    end
  end

  // transfer clock idles at the level set by polarity
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_lvl_ff <= 1'b1;
    end else if (tx_st_ff != sps_pkg::SPS_TX_SYNC) begin
      clk_lvl_ff <= !pol;
    end else if (tick && !ext) begin
      clk_lvl_ff <= !clk_lvl_ff;
    end
  end
  assign serial_clock_out = clk_lvl_ff;
  assign serial_clock_oe  = is_sync && !ext;

  // transmit frame: async start, data, optional parity, stop bits; sync eight data bits only
  always_comb begin
    frame  = 13'h1FFF;
    p_calc = (^(txb_ff & ~(9'h1FF << nbits))) ^ !psense;
    if (is_sync) begin
      for (int i = 0; i < 8; i++) begin
        frame[i] = msb ? txb_ff[7 - i] : txb_ff[i];
      end
      frame_len = 4'h8;
    end else begin
      frame[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (i < int'(nbits)) begin
          frame[i + 1] = txb_ff[i];
        end
      end
      if (pon) begin
        frame[nbits + 4'h1] = p_calc;
      end
      frame_len = nbits + {3'h0, pon} + 4'h2 + {3'h0, mode_ff[sps_pkg::MR_STOP]};
    end
  end

  assign sync_start = is_sync && te_ff && tx_idle
                      && (!ti_ff || (cont_ff && arm_ff && re_ff));
  assign uart_start = is_uart && te_ff && tx_idle && !ti_ff;
  assign tx_load    = (sync_start || uart_start) && !ti_ff;
  assign tx_end     = (tx_st_ff == sps_pkg::SPS_TX_SYNC && sample_ev && tx_idx_ff == sps_pkg::SYNC_LAST)
                   || (tx_st_ff == sps_pkg::SPS_TX_UART && ub && tx_ovs_ff == sps_pkg::OVS_LAST
                       && tx_idx_ff == tx_len_ff - 4'h1);

  // transmitter; dropping enable or mode aborts the character
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff    <= sps_pkg::SPS_TX_IDLE;
      tx_frame_ff <= 13'h1FFF;
      tx_len_ff   <= 4'h0;
      tx_idx_ff   <= 4'h0;
      tx_ovs_ff   <= 4'h0;
      tx_pin_ff   <= 1'b1;
    end else if (!te_ff || !(is_sync || is_uart)) begin
      tx_st_ff  <= sps_pkg::SPS_TX_IDLE;
      tx_pin_ff <= 1'b1;
    end else begin
      case (tx_st_ff)
        sps_pkg::SPS_TX_IDLE: begin
          tx_pin_ff <= 1'b1;
          if (sync_start || uart_start) begin
            tx_frame_ff <= ti_ff ? 13'h1FFF : frame;
            tx_len_ff   <= frame_len;
            tx_idx_ff   <= 4'h0;
            tx_ovs_ff   <= 4'h0;
            tx_st_ff    <= is_sync ? sps_pkg::SPS_TX_SYNC : sps_pkg::SPS_TX_UART;
            if (uart_start) begin
              tx_pin_ff <= frame[0];
            end
          end
        end
        sps_pkg::SPS_TX_SYNC: begin
          if (drive_ev) begin
            tx_pin_ff <= tx_frame_ff[tx_idx_ff];
          end
          if (sample_ev) begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
            if (tx_end) begin
              tx_st_ff <= sps_pkg::SPS_TX_IDLE;
            end
          end
        end
        sps_pkg::SPS_TX_UART: begin
          if (ub) begin
            tx_ovs_ff <= tx_ovs_ff + 4'h1;
            if (tx_ovs_ff == sps_pkg::OVS_LAST) begin
              tx_idx_ff <= tx_idx_ff + 4'h1;
              tx_pin_ff <= tx_end ? 1'b1 : tx_frame_ff[tx_idx_ff + 4'h1];
              if (tx_end) begin
                tx_st_ff <= sps_pkg::SPS_TX_IDLE;
              end
            end
          end
        end
        default: tx_st_ff <= sps_pkg::SPS_TX_IDLE;
      endcase
    end
  end
  assign serial_tx_pin = tx_pin_ff;

  // receive path
  sps_rx_filter u_filt (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .sample_en(ub),
    .filt_on  (c0_ff[sps_pkg::C0_DFE]),
    .rx_in    (serial_rx_pin),
    .rx_out   (rx_filt)
  );

  assign rx_total = nbits + {3'h0, pon} + 4'h1;
  assign rx_bit   = is_sync ? serial_rx_pin : rx_filt;
  assign rx_take  = (rx_st_ff == sps_pkg::SPS_RX_SYNC && sample_ev)
                 || (rx_st_ff == sps_pkg::SPS_RX_UART && ub && rx_ovs_ff == sps_pkg::OVS_LAST);
  assign rx_last  = is_sync ? (rx_idx_ff == sps_pkg::SYNC_LAST) : (rx_idx_ff == rx_total - 4'h1);
  assign rx_store = rx_take && rx_last;
  assign ovr_hit  = rx_take && (rx_idx_ff == sps_pkg::OVR_IDX) && ri_ff;

  always_comb begin
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_sh[rx_idx_ff] = rx_bit;
    rx_data = nxt_rx_sh[8:0] & ~(9'h1FF << nbits);
    if (is_sync) begin
      for (int i = 0; i < 8; i++) begin
        rx_data[i] = msb ? nxt_rx_sh[7 - i] : nxt_rx_sh[i];
      end
      rx_data[8] = 1'b0;
    end
    rx_per = !is_sync && pon && ((^rx_data) ^ nxt_rx_sh[nbits] ^ !psense);
    rx_fer = !is_sync && !nxt_rx_sh[nbits + {3'h0, pon}];
  end

  // receiver; sync reception is launched together with a transmit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff  <= sps_pkg::SPS_RX_IDLE;
      rx_sh_ff  <= 11'h7FF;
      rx_idx_ff <= 4'h0;
      rx_ovs_ff <= 4'h0;
    end else if (!re_ff || !(is_sync || is_uart)) begin
      rx_st_ff <= sps_pkg::SPS_RX_IDLE;
    end else begin
      if (rx_take) begin
        rx_sh_ff  <= nxt_rx_sh;
        rx_idx_ff <= rx_idx_ff + 4'h1;
      end
      if (ub) begin
        rx_ovs_ff <= rx_ovs_ff + 4'h1;
      end
      case (rx_st_ff)
        sps_pkg::SPS_RX_IDLE: begin
          rx_idx_ff <= 4'h0;
          rx_ovs_ff <= 4'h0;
          if (sync_start) begin
            rx_st_ff <= sps_pkg::SPS_RX_SYNC;
          end else if (is_uart && ub && !rx_filt) begin
            rx_st_ff <= sps_pkg::SPS_RX_HUNT;
          end
        end
        sps_pkg::SPS_RX_SYNC: begin
          if (rx_store) begin
            rx_st_ff <= sps_pkg::SPS_RX_IDLE;
          end
        end
        sps_pkg::SPS_RX_HUNT: begin
          if (ub && rx_ovs_ff == sps_pkg::OVS_MID) begin
            rx_ovs_ff <= 4'h0;
            rx_st_ff  <= rx_filt ? sps_pkg::SPS_RX_IDLE : sps_pkg::SPS_RX_UART;
          end
        end
        sps_pkg::SPS_RX_UART: begin
          if (rx_store) begin
            rx_st_ff <= sps_pkg::SPS_RX_IDLE;
          end
        end
        default: rx_st_ff <= sps_pkg::SPS_RX_IDLE;
      endcase
    end
  end

  // receive buffer and its status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxb_ff <= 9'h000;
      fer_ff <= 1'b0;
      per_ff <= 1'b0;
    end else if (rx_store) begin
      rxb_ff <= rx_data;
      fer_ff <= rx_fer;
      per_ff <= rx_per;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ri_ff  <= 1'b0;
      ovr_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else begin
      if (rx_store) begin
        ri_ff <= 1'b1;
      end else if (rd && idx == sps_pkg::IDX_RXL) begin
        ri_ff <= 1'b0;
      end
      if (ovr_hit) begin
        ovr_ff <= 1'b1;
      end else if (!re_ff || !(is_sync || is_uart)) begin
        ovr_ff <= 1'b0;
      end
      if (rd && idx == sps_pkg::IDX_RXL && cont_ff) begin
        arm_ff <= 1'b1;
      end else if (sync_start) begin
        arm_ff <= 1'b0;
      end
    end
  end

  mode_off_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(is_sync || is_uart) |=> tx_idle && rx_st_ff == sps_pkg::SPS_RX_IDLE)
    else $error("engines active while serial interface disabled");

  tx_start_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_load |-> te_ff && !ti_ff ##1 (ti_ff || ($past(wr) && $past(idx) == sps_pkg::IDX_TXL)))
    else $error("transmit buffer moved without enable or data");

  sync_rx_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_st_ff == sps_pkg::SPS_RX_IDLE ##1 rx_st_ff == sps_pkg::SPS_RX_SYNC
    |-> $past(re_ff) && $past(te_ff) && tx_st_ff == sps_pkg::SPS_TX_SYNC)
    else $error("sync reception began without transmit");

  sync_eight_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(tx_st_ff == sps_pkg::SPS_TX_SYNC) && $past(te_ff) && $past(is_sync)
    |-> tx_idx_ff == 4'h8)
    else $error("sync transfer did not carry eight bits");

  tx_flag_src_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tx_load && !irs_ff) || (tx_end && irs_ff) |=> txf_ff)
    else $error("transmit flag missed its event");

  rx_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_store && !ovr_ff && !ovr_hit |=> rxf_ff && ri_ff)
    else $error("receive flag not raised on store");

  overrun_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovr_hit |=> ovr_ff ##0 (rxf_ff == $past(rxf_ff) || !$past(rxf_ff)))
    else $error("overrun not flagged or done flag disturbed");

  clk_idle_pol_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_idle && $past(tx_idle) && !ext && $stable(pol) |-> serial_clock_out == !pol)
    else $error("transfer clock not at idle level");

  uart_start_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uart_start |=> !serial_tx_pin [*2])
    else $error("async character lacks low start bit");

  uart_idle_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_idle && $past(tx_idle) |-> serial_tx_pin)
    else $error("line not idle high between characters");
endmodule
`default_nettype wire

// ### dv/sps_peer.sv
`timescale 1ns/10ps
`default_nettype none
module sps_peer (
  // device pins
  input  wire logic       sclk,
  input  wire logic       tx,
  output logic            rx,
  output logic            ext_clk,
  // bench side
  input  wire logic       arm,
  input  wire logic       loop,
  input  wire logic       msb,
  input  wire logic [7:0] pdata,
  output logic [7:0]      got,
  output int              period
);
  logic [2:0] kd     = 3'h0;
  logic [2:0] kr     = 3'h0;
  logic       rx_q   = 1'b1;
  int         n_go   = 0;
  int         n_done = 0;
  realtime    t_last = 0.0;
  // held at the idle level of polarity 0
  assign ext_clk = 1'b1;
  // async loops back; a released sync line shows the inverse, not a held bit
  assign rx = loop ? tx : ((n_go == n_done) ? ~rx_q : rx_q);
  always @(negedge sclk) begin
    if (arm) begin
      rx_q <= msb ? pdata[3'h7 - kd] : pdata[kd];
      kd <= kd + 3'h1;
      if (kd == 3'h0) n_go <= n_go + 1;
    end
  end
  always @(posedge sclk) begin
    if (arm) begin
      got <= msb ? {got[6:0], tx} : {tx, got[7:1]};
      kr <= kr + 3'h1;
      period <= int'(($realtime - t_last) / 8.0);
      t_last <= $realtime;
      if (kr == 3'h7) n_done <= n_done + 1;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        tx, rx, ck_in, ck_out, ck_oe, txf, rxf, msb, loop;
  logic [7:0]  pdata, got, td, pd;
  int          period, errors, samples_checked, n;
  int          q[$];
  logic [11:0] ra[4] = '{12'h200, 12'h210, 12'h214, 12'h220};
  logic [31:0] rv[4] = '{32'h0, 32'h8, 32'h2, 32'h0};
  sps_top i_sps_top (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_tx_pin(tx), .serial_rx_pin(rx),
    .serial_clock_pin(ck_in), .serial_clock_out(ck_out), .serial_clock_oe(ck_oe),
    .tx_irq_flag(txf), .rx_done_flag(rxf));
  sps_peer i_sps_peer (.sclk(ck_out), .tx(tx), .rx(rx), .ext_clk(ck_in), .arm(resetn),
    .loop(loop), .msb, .pdata, .got, .period);
  always #4 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task print_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, msb, loop} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pdata = 8'h00;
    seed = 32'hA61A;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_value", rv[i], rd);
    end
    apb(1'b0, 12'h300, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, perr});
    for (int i = 0; i < 4; i++) begin
      n = int'(rnd() & 32'h3);
      td = 8'(rnd());
      pd = 8'(rnd());
      q.push_back(td);
      q.push_back(pd);
      msb <= i[0];
      pdata <= pd;
      apb(1'b1, 12'h204, n);
      apb(1'b1, 12'h200, 32'h1);
      apb(1'b1, 12'h210, {24'h0, i[0], 7'h0});
      apb(1'b1, 12'h214, {27'h0, i[1], 4'h5});
      apb(1'b1, 12'h208, {24'h0, td});
      for (int k = 0; k < 2000 && rxf !== 1'b1; k++) @(posedge sys_clk);
      chk("rx_flag", 32'h1, {31'h0, rxf});
      chk("tx_flag", 32'h1, {31'h0, txf});
      chk("tx_byte", q.pop_front(), {24'h0, got});
      chk("clk_period", 2 * (n + 1), period);
      apb(1'b0, 12'h218, 32'h0);
      chk("rx_byte", q.pop_front(), rd);
      apb(1'b1, 12'h220, 32'h0);
    end
    // async loopback after recovery; the third char overruns the unread second
    loop <= 1'b1;
    apb(1'b1, 12'h214, 32'h0);
    apb(1'b1, 12'h200, 32'h0);
    apb(1'b1, 12'h200, 32'h75);
    apb(1'b1, 12'h210, 32'h10);
    apb(1'b1, 12'h214, 32'h15);
    for (int i = 0; i < 3; i++) begin
      td = 8'(rnd());
      apb(1'b1, 12'h220, 32'h0);
      apb(1'b1, 12'h208, {24'h0, td});
      for (int k = 0; k < 3000 && txf !== 1'b1; k++) @(posedge sys_clk);
      chk("tx_done_flag", 32'h1, {31'h0, txf});
      chk("rx_flag_async", (i == 2) ? 32'h0 : 32'h1, {31'h0, rxf});
      apb(1'b0, 12'h21C, 32'h0);
      chk("rx_status", (i == 2) ? 32'h90 : 32'h0, rd);
      if (i == 0) begin
        apb(1'b0, 12'h218, 32'h0);
        chk("rx_byte_async", {24'h0, td}, rd);
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
